// [testbench/test_tuner_synth_mode_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module test_tuner_synth_mode_regs;
   localparam logic [1:0] STRAP = 2'h2;
   localparam int SETTLE = 20000;
   logic sys_clk, rst, scl, sda_low, sda_line, sda_pin_out, sda_pin_oe, auto_band_start;
   logic [1:0] oscillator_select, lo_divide_ratio, reference_divide, track_filter_band, if_output_format;
   logic [3:0] oscillator_subband;
   logic [2:0] oscillator_enable;
   logic [5:0] lo_divide_value, parallel_cap_code;
   logic [7:0] synth_integer_n, series_cap_code;
   logic [19:0] synth_fraction;
   logic charge_pump_mode_sel, factory_pump_bit, premixer_gain_sel, rf_input_select, rf_lowpass_enable;
   logic if_bandwidth_sel;
   logic [7:0] mdl [0:7];
   logic [7:0] wb [0:7];
   logic [8:0] rx;
   int n_fail, check_count, seed, cyc, n_pulse, exp_pulse;

   // open-drain data line with pull-up
   assign sda_line = ~sda_low & (sda_pin_oe ? sda_pin_out : 1'b1);

   tsr_synth_mode_regs DUT (
      .sys_clk(sys_clk), .rst(rst), .scl_pin(scl), .sda_pin_in(sda_line), .sda_pin_out(sda_pin_out),
      .sda_pin_oe(sda_pin_oe), .addr_strap(STRAP), .oscillator_select(oscillator_select),
      .oscillator_subband(oscillator_subband), .lo_divide_ratio(lo_divide_ratio),
      .oscillator_enable(oscillator_enable), .lo_divide_value(lo_divide_value), .synth_integer_n(synth_integer_n),
      .charge_pump_mode_sel(charge_pump_mode_sel), .factory_pump_bit(factory_pump_bit),
      .reference_divide(reference_divide), .synth_fraction(synth_fraction), .auto_band_start(auto_band_start),
      .premixer_gain_sel(premixer_gain_sel), .rf_input_select(rf_input_select),
      .rf_lowpass_enable(rf_lowpass_enable), .if_bandwidth_sel(if_bandwidth_sel),
      .track_filter_band(track_filter_band), .if_output_format(if_output_format),
      .series_cap_code(series_cap_code), .parallel_cap_code(parallel_cap_code)
   );

   tsr_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // sampled mid-cycle so the pulse is seen settled; an unknown level counts as a pulse
   always @(negedge sys_clk) begin
      cyc++;
      if (auto_band_start !== 1'b0) n_pulse++;
      if (cyc == 90000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic model_reset();
      mdl = '{tsr_pkg::RST_OSC, tsr_pkg::RST_INT, tsr_pkg::RST_FRAC_HI, tsr_pkg::RST_FRAC_MID,
         tsr_pkg::RST_FRAC_LO, tsr_pkg::RST_MODE, tsr_pkg::RST_SER, tsr_pkg::RST_PAR};
   endtask

   task automatic check_outputs();
      `CHK(oscillator_select, mdl[0][7:6])
      `CHK(oscillator_enable, (mdl[0][7:6] == 2'h3) ? 3'h0 : 3'h1 << mdl[0][7:6])
      `CHK(oscillator_subband, mdl[0][5:2])
      `CHK(lo_divide_ratio, mdl[0][1:0])
      `CHK(lo_divide_value, 6'h04 << mdl[0][1:0])
      `CHK(synth_integer_n, mdl[1])
      `CHK(charge_pump_mode_sel, mdl[2][7])
      `CHK(factory_pump_bit, mdl[2][6])
      `CHK(reference_divide, mdl[2][5:4])
      `CHK(synth_fraction, {mdl[2][3:0], mdl[3], mdl[4]})
      `CHK(premixer_gain_sel, mdl[5][7])
      `CHK(rf_input_select, mdl[5][6])
      `CHK(rf_lowpass_enable, mdl[5][5])
      `CHK(if_bandwidth_sel, mdl[5][4])
      `CHK(track_filter_band, mdl[5][3:2])
      `CHK(if_output_format, mdl[5][1:0])
      `CHK(series_cap_code, mdl[6])
      `CHK(parallel_cap_code, mdl[7][5:0])
      `CHK(n_pulse, exp_pulse)
   endtask

   task automatic wr(input logic [7:0] ptr, input int n);
      host.start();
      host.xfer({tsr_pkg::DEV_ADDR_HI, STRAP, 1'b0, 1'b1}, rx);
      `CHK(rx[0], 1'b0)
      host.xfer({ptr, 1'b1}, rx);
      for (int i = 0; i < n; i++) begin
         host.xfer({wb[i], 1'b1}, rx);
         `CHK(rx[0], 1'b0)
         if (ptr + i < 8) mdl[ptr + i] = (ptr + i == 7) ? (wb[i] & 8'h3f) : wb[i];
         if (ptr + i == 4) exp_pulse++;
      end
      host.stop();
      check_outputs();
   endtask

   task automatic rd(input logic [7:0] ptr, input int n);
      host.start();
      host.xfer({tsr_pkg::DEV_ADDR_HI, STRAP, 1'b0, 1'b1}, rx);
      host.xfer({ptr, 1'b1}, rx);
      host.start();
      host.xfer({tsr_pkg::DEV_ADDR_HI, STRAP, 1'b1, 1'b1}, rx);
      `CHK(rx[0], 1'b0)
      for (int i = 0; i < n; i++) begin
         host.xfer({8'hff, i == n - 1}, rx);
         `CHK(rx[8:1], (ptr + i < 8) ? mdl[ptr + i] : 8'h00)
      end
      host.stop();
   endtask

   initial begin
      seed = 98429;
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      model_reset();
      repeat (3) @(posedge sys_clk);
      #1;
      rd(8'h00, 8);
      check_outputs();
      $display("test reset_values done");
      repeat (SETTLE) @(posedge sys_clk);
      #1;
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 8; i++) wb[i] = 8'($random(seed));
         wb[2][7] = 1'b1;
         wb[2][5] = 1'b0;
         wr(8'h00, 8);
         rd(8'h00, 8);
      end
      $display("test random_bursts done");
      for (int k = 0; k < 4; k++) begin
         wb[0] = {2'(k), 4'($random(seed)), 2'(k)};
         wr(8'h00, 1);
         wb[0] = {4'($random(seed)), 2'(k), 2'(k)};
         wr(8'h05, 1);
         rd(8'h00, 8);
      end
      $display("test field_codes done");
      wb[0] = 8'hff;
      wb[1] = 8'ha5;
      wr(8'h07, 2);
      rd(8'h07, 2);
      $display("test mask_and_unmapped done");
      host.start();
      host.xfer({tsr_pkg::DEV_ADDR_HI, ~STRAP, 1'b0, 1'b1}, rx);
      `CHK(rx[0], 1'b1)
      host.xfer({8'h01, 1'b1}, rx);
      host.xfer({8'h00, 1'b1}, rx);
      `CHK(rx[0], 1'b1)
      host.stop();
      check_outputs();
      $display("test foreign_address done");
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      model_reset();
      repeat (3) @(posedge sys_clk);
      #1;
      rd(8'h00, 8);
      check_outputs();
      $display("test second_reset done");
      report_and_stop();
   end
endmodule // test_tuner_synth_mode_regs
`default_nettype wire

// [testbench/tsr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module tsr_host_model (
   input wire logic sys_clk,
   input wire logic sda_line,
   output var logic scl,
   output var logic sda_low
);
   // third of a bit in system clocks; each clock phase stays above four cycles
   localparam int HALF = 6;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half();
      repeat (HALF) @(posedge sys_clk);
      #1;
   endtask
   // start or repeated start, leaves the serial clock low
   task automatic start();
      sda_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      half();
      sda_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask
   // eight bits msb first then the acknowledge bit; a one releases the line
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         half();
         sda_low = ~tx[i];
         half();
         scl = 1'b1;
         half();
         rx[i] = sda_line;
         scl = 1'b0;
      end
   endtask
endmodule // tsr_host_model
`default_nettype wire

// [verilog/tsr_pkg.sv]
`default_nettype none
package tsr_pkg;
   // register offsets
   localparam logic [7:0] ADR_OSC = 8'h00;
   localparam logic [7:0] ADR_INT = 8'h01;
   localparam logic [7:0] ADR_FRAC_HI = 8'h02;
   localparam logic [7:0] ADR_FRAC_MID = 8'h03;
   localparam logic [7:0] ADR_FRAC_LO = 8'h04;
   localparam logic [7:0] ADR_MODE = 8'h05;
   localparam logic [7:0] ADR_SER = 8'h06;
   localparam logic [7:0] ADR_PAR = 8'h07;
   localparam logic [7:0] NUM_REGS = 8'h08;
   localparam int IDX_W = 3;
   // reset values, the usual startup setting
   localparam logic [7:0] RST_OSC = 8'h4c;
   localparam logic [7:0] RST_INT = 8'h2b;
   localparam logic [7:0] RST_FRAC_HI = 8'h8e;
   localparam logic [7:0] RST_FRAC_MID = 8'h26;
   localparam logic [7:0] RST_FRAC_LO = 8'h66;
   localparam logic [7:0] RST_MODE = 8'hd8;
   localparam logic [7:0] RST_SER = 8'h30;
   localparam logic [7:0] RST_PAR = 8'h12;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_PAR = 8'h3f;
   // field positions
   localparam int OSC_SEL_LSB = 6;
   localparam int SUBBAND_LSB = 2;
   localparam int LODIV_LSB = 0;
   localparam int CPS_BIT = 7;
   localparam int FPB_BIT = 6;
   localparam int REFDIV_LSB = 4;
   localparam int FRAC_HI_LSB = 0;
   localparam int GAIN_BIT = 7;
   localparam int RF_INPUT_SELECT_BIT = 6;
   localparam int LPF_BIT = 5;
   localparam int BW_BIT = 4;
   localparam int TFB_LSB = 2;
   localparam int IFSEL_LSB = 0;
   localparam int PAR_W = 6;
   // field codes
   localparam logic [1:0] OSC_OFF = 2'h3;
   localparam logic [5:0] LO_DIV_BASE = 6'h04;
   // serial bus
   localparam logic [4:0] DEV_ADDR_HI = 5'h18;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } tsr_bus_state_type;

   function automatic logic [7:0] reg_mask(input logic [IDX_W-1:0] idx);
      reg_mask = (idx == ADR_PAR[IDX_W-1:0]) ? MASK_PAR : MASK_FULL;
   endfunction

   function automatic logic [7:0] reg_reset(input logic [IDX_W-1:0] idx);
      case (idx)
         3'h0: reg_reset = RST_OSC;
         3'h1: reg_reset = RST_INT;
         3'h2: reg_reset = RST_FRAC_HI;
         3'h3: reg_reset = RST_FRAC_MID;
         3'h4: reg_reset = RST_FRAC_LO;
         3'h5: reg_reset = RST_MODE;
         3'h6: reg_reset = RST_SER;
         default: reg_reset = RST_PAR;
      endcase
   endfunction
endpackage
`default_nettype wire

// [verilog/tsr_reg_file.sv]
`timescale 1ns/10ps
`default_nettype none
module tsr_reg_file (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   output logic [7:0] osc_reg,
   output logic [7:0] int_reg,
   output logic [7:0] frac_hi_reg,
   output logic [7:0] frac_mid_reg,
   output logic [7:0] frac_lo_reg,
   output logic [7:0] mode_reg,
   output logic [7:0] ser_reg,
   output logic [7:0] par_reg,
   output logic [2:0] osc_enable,
   output logic [5:0] lo_divide_value,
   output logic auto_band_start
);
   logic [7:0] reg_q [0:7];
   logic [7:0] reg_d [0:7];
   logic [2:0] osc_en_q, osc_en_d;
   logic [5:0] lodiv_q, lodiv_d;
   logic band_q, band_d;
   logic [1:0] osc_sel_d, lodiv_code_d;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         reg_d[i] = reg_q[i];
      end
      if (wr_en && wr_addr < tsr_pkg::NUM_REGS) begin
         // unused codes are stored as written; empty bits masked
         reg_d[wr_addr[2:0]] = wr_data & tsr_pkg::reg_mask(wr_addr[2:0]);
      end
      band_d = wr_en && wr_addr == tsr_pkg::ADR_FRAC_LO;
      osc_sel_d = reg_d[0][tsr_pkg::OSC_SEL_LSB +: 2];
      osc_en_d = (osc_sel_d == tsr_pkg::OSC_OFF) ? 3'h0 : 3'(3'h1 << osc_sel_d);
      lodiv_code_d = reg_d[0][tsr_pkg::LODIV_LSB +: 2];
      lodiv_d = 6'(tsr_pkg::LO_DIV_BASE << lodiv_code_d);
      rd_data = (rd_addr < tsr_pkg::NUM_REGS) ? reg_q[rd_addr[2:0]] : 8'h00;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            reg_q[i] <= tsr_pkg::reg_reset(3'(i));
         end
         osc_en_q <= 3'(3'h1 << tsr_pkg::RST_OSC[tsr_pkg::OSC_SEL_LSB +: 2]);
         lodiv_q <= 6'(tsr_pkg::LO_DIV_BASE << tsr_pkg::RST_OSC[tsr_pkg::LODIV_LSB +: 2]);
         band_q <= 1'b0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            reg_q[i] <= reg_d[i];
         end
         osc_en_q <= osc_en_d;
         lodiv_q <= lodiv_d;
         band_q <= band_d;
      end
   end

   assign osc_reg = reg_q[0];
   assign int_reg = reg_q[1];
   assign frac_hi_reg = reg_q[2];
   assign frac_mid_reg = reg_q[3];
   assign frac_lo_reg = reg_q[4];
   assign mode_reg = reg_q[5];
   assign ser_reg = reg_q[6];
   assign par_reg = reg_q[7];
   assign osc_enable = osc_en_q;
   assign lo_divide_value = lodiv_q;
   assign auto_band_start = band_q;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_osc_shutoff: assert property ((osc_reg[tsr_pkg::OSC_SEL_LSB +: 2] == tsr_pkg::OSC_OFF) == (osc_enable == 3'h0))
      else $error("oscillator enable does not follow select");
   a_subband_keep: assert property (wr_en && wr_addr != tsr_pkg::ADR_OSC |=> $stable(osc_reg))
      else $error("sub-band register disturbed");
   a_lo_divide: assert property (lo_divide_value == 6'(tsr_pkg::LO_DIV_BASE << osc_reg[tsr_pkg::LODIV_LSB +: 2]))
      else $error("lo divide value wrong");
   a_integer_store: assert property (wr_en && wr_addr == tsr_pkg::ADR_INT |=> int_reg == $past(wr_data))
      else $error("integer divide not stored");
   a_ref_divide: assert property (wr_en && wr_addr == tsr_pkg::ADR_FRAC_HI |=> frac_hi_reg == $past(wr_data))
      else $error("reference divide not stored");
   a_frac_middle: assert property (wr_en && wr_addr == tsr_pkg::ADR_FRAC_MID |=> frac_mid_reg == $past(wr_data))
      else $error("fraction middle byte not stored");
   a_band_trigger: assert property (auto_band_start == $past(wr_en && wr_addr == tsr_pkg::ADR_FRAC_LO))
      else $error("band select start wrong");
   a_mode_store: assert property (wr_en && wr_addr == tsr_pkg::ADR_MODE |=> mode_reg == $past(wr_data))
      else $error("mode register not stored");
   a_parallel_empty: assert property (par_reg[7:tsr_pkg::PAR_W] == 2'h0)
      else $error("empty bits of parallel cap set");
   a_readback_value: assert property (wr_en && wr_addr == tsr_pkg::ADR_SER ##1 rd_addr == tsr_pkg::ADR_SER
      |-> rd_data == $past(wr_data))
      else $error("readback differs from write");
   c_band_start: cover property (auto_band_start);
   c_osc_off: cover property (osc_enable == 3'h0);
endmodule // tsr_reg_file
`default_nettype wire

// [verilog/tsr_synth_mode_regs.sv]
// Overview of operation
// - oscillator select 00/01/10 picks oscillator one to three; 11 turns it off.
// - four-bit sub-band field picks one of sixteen sub-bands.
// - lo divide code 00..11 divides by 4, 8, 16, 32.
// - integer register holds the eight-bit integer divide value.
// - reference divide 00 is one, 01 is two; host avoids upper codes.
// - twenty-bit fraction assembled from three registers, high to low.
// - each write of the low fraction byte starts band selection.
// - premixer gain bit one is nominal, zero is reduced.
// - rf input bit zero routes low band, one routes high band.
// - rf lowpass bit one enables the filter, zero disables it.
// - bandwidth bit zero is narrow mode, one is wide mode.
// - tracking band code picks low vhf, high vhf or uhf; 11 unused.
// - if output code 00 differential, 01 single ended; others unused.
// - series register holds an eight-bit tracking capacitance code.
// - parallel register holds a six-bit code; upper two bits read zero.
// - all registers read back over the serial bus.
`timescale 1ns/10ps
`default_nettype none
module tsr_synth_mode_regs (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl_pin,
   input wire logic sda_pin_in,
   output logic sda_pin_out,
   output logic sda_pin_oe,
   input wire logic [1:0] addr_strap,
   output logic [1:0] oscillator_select,
   output logic [3:0] oscillator_subband,
   output logic [1:0] lo_divide_ratio,
   output logic [2:0] oscillator_enable,
   output logic [5:0] lo_divide_value,
   output logic [7:0] synth_integer_n,
   output logic charge_pump_mode_sel,
   output logic factory_pump_bit,
   output logic [1:0] reference_divide,
   output logic [19:0] synth_fraction,
   output logic auto_band_start,
   output logic premixer_gain_sel,
   output logic rf_input_select,
   output logic rf_lowpass_enable,
   output logic if_bandwidth_sel,
   output logic [1:0] track_filter_band,
   output logic [1:0] if_output_format,
   output logic [7:0] series_cap_code,
   output logic [5:0] parallel_cap_code
);
   // pin synchronisers, third stage for edge detection
   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic sda_s1_q, sda_s2_q, sda_s3_q;
   logic [1:0] strap_s1_q, strap_s2_q;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   // serial engine state
   tsr_pkg::tsr_bus_state_type state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic ack_q, ack_d;
   logic oe_q, oe_d;
   logic out_q;
   logic wr_en_q, wr_en_d;
   logic [7:0] wr_addr_q, wr_addr_d;
   logic [7:0] wr_data_q, wr_data_d;
   logic collect;
   logic addr_match;

   // register file view
   logic [7:0] rd_data;
   logic [7:0] osc_reg, int_reg, frac_hi_reg, frac_mid_reg, frac_lo_reg;
   logic [7:0] mode_reg, ser_reg, par_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
      end else begin
         scl_s1_q <= scl_pin;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= sda_pin_in;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
         strap_s1_q <= addr_strap;
         strap_s2_q <= strap_s1_q;
      end
   end

   assign scl_rise = scl_s2_q && !scl_s3_q;
   assign scl_fall = !scl_s2_q && scl_s3_q;
   assign bus_start = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
   assign bus_stop = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;
   assign addr_match = shift_q[7:1] == {tsr_pkg::DEV_ADDR_HI, strap_s2_q};
   assign collect = state_q == tsr_pkg::ST_ADDR || state_q == tsr_pkg::ST_REG || state_q == tsr_pkg::ST_WR;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      ack_d = ack_q;
      oe_d = oe_q;
      wr_en_d = 1'b0;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      if (bus_start) begin
         state_d = tsr_pkg::ST_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end else if (bus_stop) begin
         state_d = tsr_pkg::ST_IDLE;
         oe_d = 1'b0;
      end else begin
         if (collect && scl_rise && cnt_q < tsr_pkg::BYTE_BITS) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
         end
         case (state_q)
            tsr_pkg::ST_ADDR: begin
               if (scl_fall && cnt_q == tsr_pkg::BYTE_BITS) begin
                  cnt_d = 4'h0;
                  if (addr_match) begin
                     oe_d = 1'b1;
                     rw_d = shift_q[0];
                     state_d = tsr_pkg::ST_ADDR_ACK;
                  end else begin
                     state_d = tsr_pkg::ST_IDLE;
                  end
               end
            end
            tsr_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw_q) begin
                     // first read byte comes from the current pointer
                     shift_d = rd_data;
                     oe_d = !rd_data[7];
                     state_d = tsr_pkg::ST_RD;
                  end else begin
                     oe_d = 1'b0;
                     state_d = tsr_pkg::ST_REG;
                  end
               end
            end
            tsr_pkg::ST_REG: begin
               if (scl_fall && cnt_q == tsr_pkg::BYTE_BITS) begin
                  cnt_d = 4'h0;
                  ptr_d = shift_q;
                  oe_d = 1'b1;
                  state_d = tsr_pkg::ST_REG_ACK;
               end
            end
            tsr_pkg::ST_REG_ACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  state_d = tsr_pkg::ST_WR;
               end
            end
            tsr_pkg::ST_WR: begin
               if (scl_fall && cnt_q == tsr_pkg::BYTE_BITS) begin
                  cnt_d = 4'h0;
                  wr_en_d = 1'b1;
                  wr_addr_d = ptr_q;
                  wr_data_d = shift_q;
                  oe_d = 1'b1;
                  state_d = tsr_pkg::ST_WR_ACK;
               end
            end
            tsr_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  ptr_d = ptr_q + 8'h01;
                  state_d = tsr_pkg::ST_WR;
               end
            end
            tsr_pkg::ST_RD: begin
               if (scl_rise && cnt_q < tsr_pkg::BYTE_BITS) begin
                  cnt_d = cnt_q + 4'h1;
               end
               if (scl_fall) begin
                  if (cnt_q == tsr_pkg::BYTE_BITS) begin
                     cnt_d = 4'h0;
                     oe_d = 1'b0;
                     ptr_d = ptr_q + 8'h01;
                     state_d = tsr_pkg::ST_RD_ACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d = !shift_q[6];
                  end
               end
            end
            tsr_pkg::ST_RD_ACK: begin
               if (scl_rise) begin
                  ack_d = !sda_s2_q;
               end
               if (scl_fall) begin
                  if (ack_q) begin
                     shift_d = rd_data;
                     oe_d = !rd_data[7];
                     state_d = tsr_pkg::ST_RD;
                  end else begin
                     state_d = tsr_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= tsr_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         ack_q <= 1'b0;
         oe_q <= 1'b0;
         out_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         ack_q <= ack_d;
         oe_q <= oe_d;
         out_q <= 1'b0;
         wr_en_q <= wr_en_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
      end
   end

   // open drain: the pin is only ever pulled low
   assign sda_pin_out = out_q;
   assign sda_pin_oe = oe_q;

   tsr_reg_file u_regs (
      .sys_clk(sys_clk),
      .rst(rst),
      .wr_en(wr_en_q),
      .wr_addr(wr_addr_q),
      .wr_data(wr_data_q),
      .rd_addr(ptr_q),
      .rd_data(rd_data),
      .osc_reg(osc_reg),
      .int_reg(int_reg),
      .frac_hi_reg(frac_hi_reg),
      .frac_mid_reg(frac_mid_reg),
      .frac_lo_reg(frac_lo_reg),
      .mode_reg(mode_reg),
      .ser_reg(ser_reg),
      .par_reg(par_reg),
      .osc_enable(oscillator_enable),
      .lo_divide_value(lo_divide_value),
      .auto_band_start(auto_band_start)
   );

   assign oscillator_select = osc_reg[tsr_pkg::OSC_SEL_LSB +: 2];
   assign oscillator_subband = osc_reg[tsr_pkg::SUBBAND_LSB +: 4];
   assign lo_divide_ratio = osc_reg[tsr_pkg::LODIV_LSB +: 2];
   assign synth_integer_n = int_reg;
   assign charge_pump_mode_sel = frac_hi_reg[tsr_pkg::CPS_BIT];
   assign factory_pump_bit = frac_hi_reg[tsr_pkg::FPB_BIT];
   assign reference_divide = frac_hi_reg[tsr_pkg::REFDIV_LSB +: 2];
   assign synth_fraction = {frac_hi_reg[tsr_pkg::FRAC_HI_LSB +: 4], frac_mid_reg, frac_lo_reg};
   assign premixer_gain_sel = mode_reg[tsr_pkg::GAIN_BIT];
   assign rf_input_select = mode_reg[tsr_pkg::RF_INPUT_SELECT_BIT];
   assign rf_lowpass_enable = mode_reg[tsr_pkg::LPF_BIT];
   assign if_bandwidth_sel = mode_reg[tsr_pkg::BW_BIT];
   assign track_filter_band = mode_reg[tsr_pkg::TFB_LSB +: 2];
   assign if_output_format = mode_reg[tsr_pkg::IFSEL_LSB +: 2];
   assign series_cap_code = ser_reg;
   assign parallel_cap_code = par_reg[tsr_pkg::PAR_W-1:0];

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_stop_release: assert property (bus_stop |=> !sda_pin_oe)
      else $error("data line held after stop");
   a_read_drive: assert property (state_q == tsr_pkg::ST_ADDR_ACK && scl_fall && rw_q
      |=> sda_pin_oe == !$past(rd_data[7]))
      else $error("first read bit wrong");
   a_write_issue: assert property (state_q == tsr_pkg::ST_WR && scl_fall && cnt_q == tsr_pkg::BYTE_BITS && !bus_start
      && !bus_stop |=> wr_en_q && wr_addr_q == $past(ptr_q) ##1 !wr_en_q)
      else $error("write strobe not issued once");
   a_fraction_low: assert property (wr_en_q && wr_addr_q == tsr_pkg::ADR_FRAC_LO
      |=> synth_fraction[7:0] == $past(wr_data_q) && auto_band_start)
      else $error("low fraction write lost");
   c_write_byte: cover property (wr_en_q);
   c_read_next: cover property (state_q == tsr_pkg::ST_RD_ACK && scl_fall && ack_q);
   c_read_end: cover property (state_q == tsr_pkg::ST_RD_ACK && scl_fall && !ack_q);
endmodule // tsr_synth_mode_regs
`default_nettype wire
